// ---- rtl/sdg_pkg.sv ----
// Shared constants, register map and types of the sleep and status block.
// Assumes a 200 MHz core clock and the sensor's 16-bit SPI frame format.
package sdg_pkg;

  // Core clock
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Sleep timing: one sleep LSB is half a second
  localparam int unsigned SLEEP_LSB_NS     = 500000000;
  localparam int unsigned SLEEP_LSB_CYCLES = SLEEP_LSB_NS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CNT_W      = 27;

  // Register addresses (byte addresses on the SPI link)
  localparam logic [6:0] ADDR_SLEEP_CTRL = 7'h24;
  localparam logic [6:0] ADDR_DIAG_FLAGS = 7'h26;
  localparam logic [6:0] ADDR_LOT_CODE_1 = 7'h32;
  localparam logic [6:0] ADDR_LOT_CODE_2 = 7'h34;
  localparam logic [6:0] ADDR_LOT_CODE_3 = 7'h36;
  localparam logic [6:0] ADDR_PRODUCT    = 7'h38;
  localparam logic [6:0] ADDR_SERIAL     = 7'h3A;

  // Sleep field
  localparam logic [7:0] SLEEP_RESET = 8'h00;
  localparam logic [7:0] SLEEP_INDEF = 8'hFF;

  // Diagnostic flag positions
  localparam int unsigned DIAG_SUPPLY_LOW = 0;
  localparam int unsigned DIAG_FLASH_FAIL = 2;
  localparam int unsigned DIAG_COMM_FAIL  = 3;
  localparam int unsigned DIAG_OVER_RANGE = 4;
  localparam int unsigned DIAG_SELFTEST   = 5;
  localparam int unsigned DIAG_CHECKSUM   = 6;
  localparam int unsigned DIAG_ALARM1     = 8;
  localparam int unsigned DIAG_ALARM2     = 9;
  localparam logic [15:0] DIAG_RESET      = 16'h0000;

  // Serial number field width
  localparam int unsigned SERIAL_W = 14;

  // Bit count at a frame's last serial clock edge, one less than the 16-edge frame
  localparam logic [3:0] FRAME_LAST_BIT = 4'hF;

  // Sync reset values: sclk idle high, cs_n high, din low, reset pin high
  localparam logic [3:0] PIN_SYNC_RESET = 4'hD;

  // Error conditions arriving from the sensor core
  typedef struct packed {
    logic alarm2;
    logic alarm1;
    logic checksum_fail;
    logic selftest_fail;
    logic over_range;
    logic flash_fail;
    logic supply_low;
  } sdg_cond_s;

  // One received SPI command word
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } sdg_cmd_s;

  // Sleep state, Gray along awake -> timed -> indefinite
  typedef enum logic [1:0] {
    SDG_AWAKE = 2'b00,
    SDG_TIMED = 2'b01,
    SDG_INDEF = 2'b11
  } sdg_sleep_e;

endpackage

// ---- rtl/sdg_sync.sv ----
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/10ps
module sdg_sync #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q_reg    <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// ---- rtl/sdg_sleep_timer.sv ----
// Counts down a timed sleep in half-second steps.
// Assumes start and stop are single-cycle pulses on the core clock.
`timescale 1ns/10ps
module sdg_sleep_timer #(
  parameter int unsigned LSB_CYCLES = sdg_pkg::SLEEP_LSB_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       start,
  input  wire logic [7:0] steps,
  input  wire logic       stop,
  // Status
  output logic            running
);
  import sdg_pkg::*;

  localparam logic [SLEEP_CNT_W-1:0] LSB_LAST =
    SLEEP_CNT_W'(LSB_CYCLES - 1);

  logic [SLEEP_CNT_W-1:0] cyc_reg;
  logic [SLEEP_CNT_W-1:0] cyc_next;
  logic [7:0]             left_reg;
  logic [7:0]             left_next;

  always_comb begin
    cyc_next  = cyc_reg;
    left_next = left_reg;
    if (stop) begin
      cyc_next  = '0;
      left_next = 8'h00;
    end else if (start) begin
      // Zero steps means no sleep at all
      cyc_next  = '0;
      left_next = steps;
    end else if (left_reg != 8'h00) begin
      if (cyc_reg == LSB_LAST) begin
        cyc_next  = '0;
        left_next = left_reg - 8'h01;
      end else begin
        cyc_next = cyc_reg + SLEEP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg  <= '0;
      left_reg <= 8'h00;
    end else begin
      cyc_reg  <= cyc_next;
      left_reg <= left_next;
    end
  end

  assign running = (left_reg != 8'h00);

endmodule

// ---- rtl/sdg_sleep_diag.sv ----
// Sleep control, diagnostic flags and identification registers behind the
// sensor's SPI slave port (mode 3, 16-bit frames, reply in the next frame).
// Assumes SPI pins and the reset pin are asynchronous and slow against clk;
// error conditions and sample_tick come from logic on clk.
//
// Operation
// RULE1: Writing 0xFF to the sleep byte enters sleep until a wake event.
// RULE2: Chip-select falling edge or reset pin pulse wakes the device.
// RULE3: Sleep values 0x00 to 0xFE sleep value times half a second.
// RULE4: Each diagnostic flag reads one for error, zero for normal.
// RULE5: Reading the diagnostic register returns flags then clears them all.
// RULE6: A persisting error sets its flag again at the next sample end.
// RULE7: Supply-low flag bit 0 set below 4.75 V, self-clears on recovery.
// RULE8: Bit 3 sets when a frame's clock edges are not a multiple of 16.
// RULE9: Bits 9, 8, 4, 2: alarm two, alarm one, over range, flash fail.
// RULE10: Bit 6 checksum fail, bit 5 self-test fail; 15:10, 7, 1 unused.
// RULE11: The diagnostic register is all zeros after reset.
// RULE12: A read-only register holds a fixed 16-bit product code.
// RULE13: Three read-only 16-bit registers return binary lot codes.
// RULE14: Serial register gives 1 to 9999 in bits 13:0, top bits zero.
// RULE15: Upper byte of sleep control is unused; low byte selects sleep.
// RULE16: Writes to identification, lot and serial registers are ignored.
// RULE17: Timed sleep starts at the write and ends early on a wake event.
`timescale 1ns/10ps
module sdg_sleep_diag #(
  // Arbitrary identification values, replaced per part and lot
  parameter logic [15:0]  PRODUCT_CODE = 16'h5A5A,
  parameter logic [15:0]  LOT_CODE_1   = 16'h1111,
  parameter logic [15:0]  LOT_CODE_2   = 16'h2222,
  parameter logic [15:0]  LOT_CODE_3   = 16'h3333,
  parameter logic [13:0]  UNIT_SERIAL  = 14'h0001,
  // Half-second length in clocks, shortened in simulation
  parameter int unsigned  SLEEP_LSB_CYCLES = sdg_pkg::SLEEP_LSB_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // SPI slave pins
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              din,
  output logic                   dout,
  // Reset pin, used here as a wake source
  input  wire logic              rst_pin_n,
  // Error conditions from the sensor core
  input  wire sdg_pkg::sdg_cond_s cond,
  input  wire logic              sample_tick,
  // Power state
  output logic                   sleeping,
  output logic                   sleep_indef
);
  import sdg_pkg::*;

  // Reset release and pin synchronisers
  logic       rst_sync_n;
  logic [3:0] pins_s;
  logic       s_sclk;
  logic       s_cs_n;
  logic       s_din;
  logic       s_rst_pin_n;

  sdg_sync #(
    .W         (1),
    .RESET_VAL (1'b0)
  ) u_rst_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rst_sync_n)
  );

  sdg_sync #(
    .W         (4),
    .RESET_VAL (PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     ({sclk, cs_n, din, rst_pin_n}),
    .q     (pins_s)
  );

  assign s_sclk      = pins_s[3];
  assign s_cs_n      = pins_s[2];
  assign s_din       = pins_s[1];
  assign s_rst_pin_n = pins_s[0];

  // Edge detection on synchronised pins
  // Delay flops reset to the pins' idle levels; a mismatch would fake an
  // edge, and so a wake, straight after reset
  logic sclk_d_reg;
  logic cs_d_reg;
  logic rpin_d_reg;
  logic sclk_d_next;
  logic cs_d_next;
  logic rpin_d_next;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic rpin_rise;

  always_comb begin
    sclk_d_next = s_sclk;
    cs_d_next   = s_cs_n;
    rpin_d_next = s_rst_pin_n;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sclk_d_reg <= 1'b1;
      cs_d_reg   <= 1'b1;
      rpin_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_d_next;
      cs_d_reg   <= cs_d_next;
      rpin_d_reg <= rpin_d_next;
    end
  end

  assign sclk_rise = s_sclk & ~sclk_d_reg & ~s_cs_n;
  assign sclk_fall = ~s_sclk & sclk_d_reg & ~s_cs_n;
  assign cs_fall   = cs_d_reg & ~s_cs_n;
  assign cs_rise   = ~cs_d_reg & s_cs_n;
  // Pin low then released
  assign rpin_rise = s_rst_pin_n & ~rpin_d_reg;

  // Read mux over the register map
  // Odd addresses fold onto their even word, as the host reads 16 bits
  logic [15:0] diag_reg;
  logic [7:0]  sleep_reg;

  function automatic logic [15:0] read_word(input logic [6:0] a,
                                            input logic [15:0] diag,
                                            input logic [7:0]  slp);
    logic [6:0] even;
    even = {a[6:1], 1'b0};
    unique case (even)
      ADDR_SLEEP_CTRL: read_word = {8'h00, slp};             // RULE15
      ADDR_DIAG_FLAGS: read_word = diag;                     // RULE4
      ADDR_LOT_CODE_1: read_word = LOT_CODE_1;               // RULE13
      ADDR_LOT_CODE_2: read_word = LOT_CODE_2;               // RULE13
      ADDR_LOT_CODE_3: read_word = LOT_CODE_3;               // RULE13
      ADDR_PRODUCT:    read_word = PRODUCT_CODE;             // RULE12
      ADDR_SERIAL:     read_word = {2'b00, UNIT_SERIAL};     // RULE14
      default:         read_word = 16'h0000;
    endcase
  endfunction

  // SPI shifter
  // Counter wraps at 16, so a good frame leaves it at zero on cs_n rise
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  bit_cnt_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [15:0] tx_reg;
  logic [15:0] tx_next;
  sdg_cmd_s    cmd;
  logic        word_done;
  logic        diag_read;
  logic        sleep_write;
  logic        frame_bad;

  assign cmd       = sdg_cmd_s'({rx_reg[14:0], s_din});
  assign word_done = sclk_rise && (bit_cnt_reg == FRAME_LAST_BIT);
  assign diag_read = word_done && !cmd.write &&
                     ({cmd.addr[6:1], 1'b0} == ADDR_DIAG_FLAGS);
  // Only the low byte address accepts data; all else is read-only
  assign sleep_write = word_done && cmd.write &&
                       (cmd.addr == ADDR_SLEEP_CTRL);        // RULE15 RULE16
  assign frame_bad = cs_rise && (bit_cnt_reg != 4'h0);       // RULE8

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    if (cs_fall) begin
      bit_cnt_next = 4'h0;
    end else if (sclk_rise) begin
      rx_next      = {rx_reg[14:0], s_din};
      bit_cnt_next = bit_cnt_reg + 4'h1;
      if (word_done) begin
        // Reply is held for the next frame; writes reply with zero
        tx_next = cmd.write ? 16'h0000 :
                  read_word(cmd.addr, diag_reg, sleep_reg);
      end
    end else if (sclk_fall && (bit_cnt_reg != 4'h0)) begin
      // No shift on a frame's first falling edge: msb already out
      tx_next = {tx_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bit_cnt_reg <= 4'h0;
      rx_reg      <= 16'h0000;
      tx_reg      <= 16'h0000;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
    end
  end

  // Driven even with cs_n high; the pin's own buffer is outside this block
  assign dout = tx_reg[15];

  // Diagnostic flags; sets are applied after the read clear so they win
  logic [15:0] diag_next;
  logic [15:0] diag_set;

  always_comb begin
    diag_set = 16'h0000;
    if (sample_tick) begin
      diag_set[DIAG_SUPPLY_LOW] = cond.supply_low;           // RULE7
      diag_set[DIAG_FLASH_FAIL] = cond.flash_fail;           // RULE9
      diag_set[DIAG_OVER_RANGE] = cond.over_range;           // RULE9
      diag_set[DIAG_SELFTEST]   = cond.selftest_fail;        // RULE10
      diag_set[DIAG_CHECKSUM]   = cond.checksum_fail;        // RULE10
      diag_set[DIAG_ALARM1]     = cond.alarm1;               // RULE9
      diag_set[DIAG_ALARM2]     = cond.alarm2;               // RULE9
    end
    // Not gated by sample_tick: the bad frame itself is the event
    diag_set[DIAG_COMM_FAIL] = frame_bad;                    // RULE8
    diag_next = diag_reg;
    if (diag_read) begin
      diag_next = 16'h0000;                                  // RULE5
    end
    if (!cond.supply_low) begin
      diag_next[DIAG_SUPPLY_LOW] = 1'b0;                     // RULE7
    end
    diag_next = diag_next | diag_set;                        // RULE6
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      diag_reg <= DIAG_RESET;                                // RULE11
    end else begin
      diag_reg <= diag_next;
    end
  end

  // Sleep control
  // A wake also clears the timer so a stale count cannot end a later
  // sleep early
  sdg_sleep_e state_reg;
  sdg_sleep_e state_next;
  logic [7:0] sleep_next;
  logic       wake;
  logic       timer_start;
  logic       timer_running;

  assign wake        = cs_fall | rpin_rise;                  // RULE2
  assign timer_start = sleep_write && (cmd.data != SLEEP_INDEF);

  sdg_sleep_timer #(
    .LSB_CYCLES (SLEEP_LSB_CYCLES)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .start   (timer_start),                                  // RULE3
    .steps   (cmd.data),
    .stop    (wake),                                         // RULE17
    .running (timer_running)
  );

  always_comb begin
    sleep_next = sleep_reg;
    state_next = state_reg;
    if (sleep_write) begin
      sleep_next = cmd.data;
    end
    if (wake) begin
      state_next = SDG_AWAKE;                                // RULE2 RULE17
    end else if (sleep_write) begin
      if (cmd.data == SLEEP_INDEF) begin
        state_next = SDG_INDEF;                              // RULE1
      end else if (cmd.data != 8'h00) begin
        state_next = SDG_TIMED;                              // RULE3 RULE17
      end else begin
        state_next = SDG_AWAKE;
      end
    end else begin
      unique case (state_reg)
        SDG_AWAKE: state_next = SDG_AWAKE;
        // Timer was loaded on the same edge as entry
        SDG_TIMED: state_next = timer_running ? SDG_TIMED : SDG_AWAKE;
        SDG_INDEF: state_next = SDG_INDEF;                   // RULE1
        default:   state_next = SDG_AWAKE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= SDG_AWAKE;
      sleep_reg <= SLEEP_RESET;
    end else begin
      state_reg <= state_next;
      sleep_reg <= sleep_next;
    end
  end

  assign sleeping    = (state_reg != SDG_AWAKE);
  assign sleep_indef = (state_reg == SDG_INDEF);

endmodule

// ---- test/sdg_sleep_diag_assertions.sv ----
// Checker for the sleep outputs of sdg_sleep_diag, bound to its ports.
// Assumes wake and write events come through 2-flop pin synchronisers.
`timescale 1ns/10ps
module sdg_sleep_diag_assertions #(
  parameter int unsigned SLEEP_LSB_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wake sources
  input wire logic cs_n,
  input wire logic rst_pin_n,
  // Power state
  input wire logic sleeping,
  input wire logic sleep_indef
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles with no wake source active, saturating; sync delay hides wakes
  logic [2:0] quiet_cnt;
  int         slp_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_cnt <= 3'h0;
      slp_cnt   <= 0;
    end else begin
      quiet_cnt <= (!cs_n || !rst_pin_n) ? 3'h0 :
                   (quiet_cnt == 3'h7) ? 3'h7 : quiet_cnt + 3'h1;
      slp_cnt   <= sleeping ? slp_cnt + 1 : 0;
    end
  end

  property p_indef_sleeps;
    sleep_indef |-> sleeping;
  endproperty
  a_indef_sleeps: assert property (p_indef_sleeps)
    else $error("indefinite sleep without sleeping");

  property p_indef_holds;
    sleep_indef && quiet_cnt >= 3'h6 |=> sleep_indef;
  endproperty
  a_indef_holds: assert property (p_indef_holds)
    else $error("indefinite sleep left without wake");

  property p_indef_entry;
    $rose(sleep_indef) |-> $rose(sleeping);
  endproperty
  a_indef_entry: assert property (p_indef_entry)
    else $error("indefinite sleep entered from timed sleep");

  property p_cs_wake;
    $fell(cs_n) && sleeping |-> ##[1:6] !sleeping;
  endproperty
  a_cs_wake: assert property (p_cs_wake)
    else $error("chip select fall did not wake");

  property p_pin_wake;
    $rose(rst_pin_n) && sleeping |-> ##[1:6] !sleeping;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("reset pin pulse did not wake");

  property p_timed_length;
    $fell(sleeping) && quiet_cnt == 3'h7 |-> slp_cnt >= SLEEP_LSB_CYCLES;
  endproperty
  a_timed_length: assert property (p_timed_length)
    else $error("timed sleep ended too early");

  property p_timed_stays;
    sleeping && !sleep_indef && quiet_cnt >= 3'h6 |=> !sleep_indef;
  endproperty
  a_timed_stays: assert property (p_timed_stays)
    else $error("timed sleep turned indefinite");

  property p_entry_on_write;
    $rose(sleeping) |-> quiet_cnt < 3'h6;
  endproperty
  a_entry_on_write: assert property (p_entry_on_write)
    else $error("sleep entered outside a frame");
endmodule

bind sdg_sleep_diag sdg_sleep_diag_assertions #(
  .SLEEP_LSB_CYCLES(SLEEP_LSB_CYCLES)
) u_sdg_sleep_diag_assertions (
  .clk(clk),
  .rst_n(rst_n),
  .cs_n(cs_n),
  .rst_pin_n(rst_pin_n),
  .sleeping(sleeping),
  .sleep_indef(sleep_indef)
);

// ---- test/sdg_host_model.sv ----
// SPI master model standing in for the host processor.
// Assumes the bench calls xfer; mode 3, 80 ns sclk from a 5 ns clk.
`timescale 1ns/10ps
module sdg_host_model (
  // Clock
  input  wire logic clk,
  // SPI pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // One frame of nbits, msb first; sclk still outside frames
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      output logic [31:0] rx);
    rx = 32'h0;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      din  <= tx[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[30:0], dout};
      repeat (8) @(posedge clk);
    end
    cs_n <= 1'b1;
    // Released line must not keep the last bit
    din  <= ~din;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for sdg_sleep_diag through its SPI port.
// Assumes sdg_host_model for the SPI side; sleep steps shortened to 20 clk.
`timescale 1ns/10ps
`define check_eq(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb;
  import sdg_pkg::*;
  localparam int unsigned LSB = 20;
  // Arbitrary identity values
  localparam logic [15:0] P_ID = 16'hC3A5;
  localparam logic [13:0] SER  = 14'h270F;
  localparam logic [15:0] LOT1 = 16'h0C1D;
  localparam logic [15:0] LOT2 = 16'h7E02;
  localparam logic [15:0] LOT3 = 16'h9B30;

  logic        clk, rst_n, sclk, cs_n, din, dout, rst_pin_n;
  logic        sample_tick, sleeping, sleep_indef;
  sdg_cond_s   cond;
  int          fails, check_count, n;
  logic [31:0] rx;
  logic [15:0] val;
  logic [6:0]  ids[5] = '{ADDR_PRODUCT, ADDR_LOT_CODE_1, ADDR_LOT_CODE_2,
                          ADDR_LOT_CODE_3, ADDR_SERIAL};
  logic [15:0] idv[5] = '{P_ID, LOT1, LOT2, LOT3,
                          {2'b00, SER}};

  sdg_sleep_diag #(
    .PRODUCT_CODE(P_ID),
    .LOT_CODE_1(LOT1),
    .LOT_CODE_2(LOT2),
    .LOT_CODE_3(LOT3),
    .UNIT_SERIAL(SER),
    .SLEEP_LSB_CYCLES(LSB)
  ) u_sdg_sleep_diag (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .rst_pin_n(rst_pin_n), .cond(cond),
    .sample_tick(sample_tick), .sleeping(sleeping),
    .sleep_indef(sleep_indef)
  );
  sdg_host_model u_sdg_host_model (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_sdg_host_model.xfer({16'h0000, 1'b1, a, d}, 16, rx);
  endtask

  // Reply comes in the following frame
  task automatic rdchk(input string nm, input logic [6:0] a,
                       input logic [15:0] e);
    u_sdg_host_model.xfer({16'h0000, 1'b0, a, 8'h00}, 16, rx);
    u_sdg_host_model.xfer(32'h0, 16, rx);
    val = rx[15:0];
    `check_eq(nm, e, val)
  endtask

  task automatic tick();
    @(posedge clk);
    sample_tick <= 1'b1;
    @(posedge clk);
    sample_tick <= 1'b0;
  endtask

  task automatic pin_wake();
    @(posedge clk);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    rst_n       = 1'b0;
    rst_pin_n   = 1'b1;
    sample_tick = 1'b0;
    cond        = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("diag reset", ADDR_DIAG_FLAGS, DIAG_RESET);
    rdchk("sleep reset", ADDR_SLEEP_CTRL, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(ids[i], 8'hFF);
      wr(ids[i] + 7'h01, 8'h00);
      rdchk("ident", ids[i], idv[i]);
    end
    rdchk("unmapped", 7'h40, 16'h0000);
    $display("test ident done");

    cond <= '1;
    tick();
    cond <= sdg_cond_s'(7'h01);
    rdchk("diag all", ADDR_DIAG_FLAGS, 16'h0375);
    rdchk("diag cleared", ADDR_DIAG_FLAGS, 16'h0000);
    tick();
    rdchk("diag again", ADDR_DIAG_FLAGS, 16'h0001);
    tick();
    cond <= '0;
    rdchk("supply ok", ADDR_DIAG_FLAGS, 16'h0000);
    cond <= sdg_cond_s'(7'h54);
    tick();
    cond <= '0;
    rdchk("diag some", ADDR_DIAG_FLAGS, 16'h0250);
    u_sdg_host_model.xfer(32'h0, 12, rx);
    rdchk("short frame", ADDR_DIAG_FLAGS, 16'h0008);
    u_sdg_host_model.xfer(32'h0, 32, rx);
    rdchk("long frame", ADDR_DIAG_FLAGS, 16'h0000);
    $display("test diag done");

    wr(ADDR_SLEEP_CTRL, SLEEP_INDEF);
    repeat (100) @(posedge clk);
    `check_eq("indef", 2'b11, {sleeping, sleep_indef})
    pin_wake();
    `check_eq("pin wake", 2'b00, {sleeping, sleep_indef})
    wr(ADDR_SLEEP_CTRL, SLEEP_INDEF);
    wr(7'h25, 8'hAB);
    `check_eq("cs wake", 2'b00, {sleeping, sleep_indef})
    rdchk("sleep byte", ADDR_SLEEP_CTRL, 16'h00FF);
    wr(ADDR_SLEEP_CTRL, 8'h03);
    `check_eq("timed", 2'b10, {sleeping, sleep_indef})
    n = 0;
    while (sleeping !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `check_eq("timed length", 1'b1, n >= 3*LSB-20 && n <= 3*LSB)
    wr(ADDR_SLEEP_CTRL, 8'hFE);
    `check_eq("max timed", 2'b10, {sleeping, sleep_indef})
    pin_wake();
    `check_eq("early end", 1'b0, sleeping)
    wr(ADDR_SLEEP_CTRL, 8'hFE);
    u_sdg_host_model.xfer(32'h0, 16, rx);
    `check_eq("cs early end", 1'b0, sleeping)
    wr(ADDR_SLEEP_CTRL, 8'h00);
    `check_eq("zero sleep", 1'b0, sleeping)
    $display("test sleep done");
    finish_test();
  end
endmodule
